/* File: mrid_decode.sv */
// instruction word decoder with one/two instruction cycle sequencing
`default_nettype none

module mrid_decode import mrid_pkg::*; #(
  parameter logic [FILE_W-1:0] PCL_ADDR = PCL_ADDR_RST  // file address of program_counter low byte
) (
  input  wire logic               clk,            // oscillator clock, 100 MHz
  input  wire logic               rst_n,          // async reset, active low
  input  wire logic [INSTR_W-1:0] instr_word,     // fetched word, sampled at cycle start
  input  wire logic               test_true,      // skip condition met, valid at cycle end
  output logic                    instr_taken,    // a new word was decoded this cycle
  output logic                    nop_cycle,      // second cycle, executed as NOP
  output mrid_class_e             op_class,       // operation group
  output logic [5:0]              op_code,        // upper six opcode bits
  output logic [FILE_W-1:0]       file_addr,      // addressed file register
  output logic [BIT_W-1:0]        bit_sel,        // selected bit
  output logic [LIT_L_W-1:0]      literal,        // literal, zero extended
  output logic                    lit_long,       // literal is eleven bits
  output logic                    result_to_w,    // result goes to W
  output logic                    result_to_file, // result goes to file register
  output logic                    pc_alter,       // instruction changes program_counter
  output logic                    skip_op,        // conditional skip instruction
  output logic [1:0]              q_phase         // oscillator period within cycle
);
  typedef struct packed {
    mrid_state_e        st;
    logic               taken;
    logic               nop;
    mrid_class_e        cls;
    logic [5:0]         opc;
    logic [FILE_W-1:0]  fadr;
    logic [BIT_W-1:0]   bsel;
    logic [LIT_L_W-1:0] lit;
    logic               llong;
    logic               to_w;
    logic               to_f;
    logic               pcalt;
    logic               skip;
    logic [1:0]         qph;
  } mrid_dec_s;

  mrid_dec_s   cur_ff, nxt_cur;
  logic [1:0]  ph_q;
  logic        cyc_start;
  logic        two_cyc;
  logic [1:0]  grp;
  logic        ctl_zero;

  ////////////////////////////////////////////////////////////////////////////
  // four-period cycle timing
  mrid_phase #(
    .OSC_N     (OSC_PER_CYC)
  ) u_phase (
    .clk       (clk),
    .rst_n     (rst_n),
    .q_phase   (ph_q),
    .cyc_start (cyc_start)
  );

  ////////////////////////////////////////////////////////////////////////////
  // field extraction and sequencing
  assign grp      = instr_word[OP_MSB:OP_LSB];
  // 00 0000 0xxx xxxx holds control ops and NOP, not byte ops
  assign ctl_zero = (instr_word[OP_MSB:8] == 6'h00) && !instr_word[DEST_POS];
  // previous instruction needs a flush cycle
  assign two_cyc  = cur_ff.pcalt || (cur_ff.skip && test_true);

  always_comb begin
    nxt_cur       = cur_ff;
    nxt_cur.qph   = ph_q;
    nxt_cur.taken = 1'b0;
    if (cyc_start) begin
      if (cur_ff.st == MRID_ST_EXEC && two_cyc) begin
        // prefetched word is discarded; write and flow outputs go quiet for the NOP, decoded fields hold
        nxt_cur.st    = MRID_ST_NOP;
        nxt_cur.nop   = 1'b1;
        nxt_cur.to_w  = 1'b0;
        nxt_cur.to_f  = 1'b0;
        nxt_cur.pcalt = 1'b0;
        nxt_cur.skip  = 1'b0;
      end else begin
        nxt_cur.st    = MRID_ST_EXEC;
        nxt_cur.taken = 1'b1;
        nxt_cur.nop   = 1'b0;
        nxt_cur.opc   = instr_word[OP_MSB:8];
        nxt_cur.fadr  = instr_word[FILE_LSB +: FILE_W];
        nxt_cur.bsel  = instr_word[BIT_LSB +: BIT_W];
        nxt_cur.lit   = '0;
        nxt_cur.llong = 1'b0;
        nxt_cur.to_w  = 1'b0;
        nxt_cur.to_f  = 1'b0;
        nxt_cur.pcalt = 1'b0;
        nxt_cur.skip  = 1'b0;
        if (grp == GRP_BYTE && !ctl_zero) begin
          nxt_cur.cls   = MRID_CLS_BYTE;
          nxt_cur.to_w  = !instr_word[DEST_POS];
          nxt_cur.to_f  = instr_word[DEST_POS];
          nxt_cur.skip  = (instr_word[11:8] == BYTE_DECSKIP) ||
                          (instr_word[11:8] == BYTE_INCSKIP);
          // writing the program_counter low byte is a jump
          nxt_cur.pcalt = instr_word[DEST_POS] &&
                          (instr_word[FILE_LSB +: FILE_W] == PCL_ADDR);
        end else if (grp == GRP_BIT) begin
          nxt_cur.cls   = MRID_CLS_BIT;
          nxt_cur.skip  = instr_word[11:10] > BIT_TEST_HI;
          nxt_cur.pcalt = !instr_word[11] &&
                          (instr_word[FILE_LSB +: FILE_W] == PCL_ADDR);
        end else if (grp == GRP_JUMP) begin
          nxt_cur.cls   = MRID_CLS_LITCTL;
          nxt_cur.lit   = instr_word[LIT_L_W-1:0];
          nxt_cur.llong = 1'b1;
          nxt_cur.pcalt = 1'b1;
        end else if (grp == GRP_BYTE) begin
          // control ops: only exact codes count, others behave as NOP
          nxt_cur.cls   = MRID_CLS_LITCTL;
          nxt_cur.pcalt = (instr_word == CTL_RETURN) || (instr_word == CTL_RETINT);
        end else begin
          // short literal: bits 11:8 partly don't-care, never widen into lit
          nxt_cur.cls   = MRID_CLS_LITCTL;
          nxt_cur.lit   = {3'h0, instr_word[LIT_S_W-1:0]};
          nxt_cur.to_w  = 1'b1;
          nxt_cur.pcalt = (instr_word[11:10] == LIT_RETLIT);
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign instr_taken    = cur_ff.taken;
  assign nop_cycle      = cur_ff.nop;
  assign op_class       = cur_ff.cls;
  assign op_code        = cur_ff.opc;
  assign file_addr      = cur_ff.fadr;
  assign bit_sel        = cur_ff.bsel;
  assign literal        = cur_ff.lit;
  assign lit_long       = cur_ff.llong;
  assign result_to_w    = cur_ff.to_w;
  assign result_to_file = cur_ff.to_f;
  assign pc_alter       = cur_ff.pcalt;
  assign skip_op        = cur_ff.skip;
  assign q_phase        = cur_ff.qph;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_quiet_cycle;
    cur_ff.nop [*4];
  endsequence

  sequence s_resume;
    cur_ff.taken && !cur_ff.nop;
  endsequence

  AST_CLASS: assert property (@(posedge clk) disable iff (!rst_n)
    cur_ff.taken |-> (cur_ff.opc == $past(instr_word[13:8])) &&
      ((cur_ff.cls == MRID_CLS_BIT) == ($past(instr_word[13:12]) == GRP_BIT)))
    else $error("class or opcode not taken from word");

  AST_DEST: assert property (@(posedge clk) disable iff (!rst_n)
    cur_ff.taken && cur_ff.cls == MRID_CLS_BYTE |->
      cur_ff.to_f == $past(instr_word[7]) && cur_ff.to_w != cur_ff.to_f)
    else $error("destination select misrouted");

  AST_FILE: assert property (@(posedge clk) disable iff (!rst_n)
    cur_ff.taken |-> cur_ff.fadr == $past(instr_word[6:0]))
    else $error("file address field wrong");

  AST_BITSEL: assert property (@(posedge clk) disable iff (!rst_n)
    cur_ff.taken && cur_ff.cls == MRID_CLS_BIT |-> cur_ff.bsel == $past(instr_word[9:7]))
    else $error("bit select field wrong");

  AST_LITERAL: assert property (@(posedge clk) disable iff (!rst_n)
    cur_ff.taken && cur_ff.llong |-> cur_ff.lit == $past(instr_word[10:0]))
    else $error("long literal wrong");

  AST_DONTCARE: assert property (@(posedge clk) disable iff (!rst_n)
    cur_ff.taken && cur_ff.cls == MRID_CLS_LITCTL && !cur_ff.llong |-> cur_ff.lit[10:8] == 3'h0)
    else $error("don't-care bits leaked into literal");

  // short literal group must carry the low byte of the word unchanged
  AST_SHORT_LIT: assert property (@(posedge clk) disable iff (!rst_n)
    cur_ff.taken && $past(instr_word[13:12]) == 2'h3 |-> cur_ff.lit == {3'h0, $past(instr_word[7:0])})
    else $error("short literal wrong");

  // a flush cycle writes nothing and cannot chain another flush
  AST_NOP_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
    cur_ff.nop |-> !cur_ff.taken && !cur_ff.to_w && !cur_ff.to_f && !cur_ff.pcalt && !cur_ff.skip)
    else $error("flush cycle not quiet");

  AST_ONE_CYC: assert property (@(posedge clk) disable iff (!rst_n)
    cyc_start && cur_ff.st == MRID_ST_EXEC && !two_cyc |=> s_resume)
    else $error("single-cycle instruction stalled");

  AST_TWO_CYC: assert property (@(posedge clk) disable iff (!rst_n)
    cyc_start && cur_ff.st == MRID_ST_EXEC && two_cyc |=> s_quiet_cycle ##1 s_resume)
    else $error("flush cycle missing or wrong length");

  AST_PERIOD: assert property (@(posedge clk) disable iff (!rst_n)
    cyc_start |=> !cyc_start [*3] ##1 cyc_start)
    else $error("instruction cycle is not four periods");
endmodule : mrid_decode

`default_nettype wire

/* File: mrid_phase.sv */
// package of shared constants and the oscillator-period phase divider
`default_nettype none

package mrid_pkg;
  localparam int INSTR_W      = 14;      // instruction word width
  localparam int FILE_W       = 7;       // file address width, 0x00..0x7F
  localparam int BIT_W        = 3;       // bit-select width
  localparam int LIT_S_W      = 8;       // short literal width
  localparam int LIT_L_W      = 11;      // long literal width
  localparam int OSC_PER_CYC  = 4;       // oscillator periods per instruction cycle
  localparam int FILE_LSB     = 0;       // file field position
  localparam int DEST_POS     = 7;       // destination select bit
  localparam int BIT_LSB      = 7;       // bit-select field position
  localparam int OP_MSB       = 13;      // class bits msb
  localparam int OP_LSB       = 12;      // class bits lsb
  localparam logic [1:0] GRP_BYTE = 2'h0;  // top bits of byte group
  localparam logic [1:0] GRP_BIT  = 2'h1;  // top bits of bit group
  localparam logic [1:0] GRP_JUMP = 2'h2;  // top bits of long-literal jumps
  localparam logic [3:0] BYTE_DECSKIP = 4'hB;  // decrement, skip if zero
  localparam logic [3:0] BYTE_INCSKIP = 4'hF;  // increment, skip if zero
  localparam logic [1:0] BIT_TEST_HI  = 2'h1;  // bit ops 1x are tests
  localparam logic [1:0] LIT_RETLIT   = 2'h1;  // 11 01xx returns with literal
  localparam logic [13:0] CTL_RETURN  = 14'h0008;  // subroutine return
  localparam logic [13:0] CTL_RETINT  = 14'h0009;  // interrupt return
  localparam logic [6:0]  PCL_ADDR_RST = 7'h02;   // low program_counter byte address

  typedef enum logic [1:0] {MRID_CLS_BYTE, MRID_CLS_BIT, MRID_CLS_LITCTL} mrid_class_e;
  typedef enum logic {MRID_ST_EXEC, MRID_ST_NOP} mrid_state_e;
endpackage : mrid_pkg

////////////////////////////////////////////////////////////////////////////////
module mrid_phase import mrid_pkg::*; #(
  parameter int OSC_N = OSC_PER_CYC              // oscillator periods per cycle
) (
  input  wire logic                     clk,       // oscillator clock
  input  wire logic                     rst_n,     // async reset, active low
  output logic [$clog2(OSC_N)-1:0]      q_phase,   // current quarter of the cycle
  output logic                          cyc_start  // high in first period of a cycle
);
  typedef struct packed {
    logic [$clog2(OSC_N)-1:0] cnt;
    logic                     start;
  } mrid_ph_s;

  mrid_ph_s cur_ff, nxt_cur;

  // wrap counter; start flag is registered so it is glitch free
  always_comb begin
    nxt_cur = cur_ff;
    if (cur_ff.cnt == ($clog2(OSC_N))'(OSC_N - 1)) begin
      nxt_cur.cnt = '0;
    end else begin
      nxt_cur.cnt = cur_ff.cnt + 1'b1;
    end
    nxt_cur.start = (nxt_cur.cnt == '0);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign q_phase   = cur_ff.cnt;
  assign cyc_start = cur_ff.start;
endmodule : mrid_phase

`default_nettype wire

/* File: mrid_prog_mem.sv */
// program memory model presenting fetched instruction words to the decoder
`default_nettype none

module mrid_prog_mem import mrid_pkg::*; (
  input  wire logic               instr_taken, // decode pulse from the core
  input  wire logic [INSTR_W-1:0] word_in,     // word at the fetch address
  output logic      [INSTR_W-1:0] instr_word   // fetch bus toward the decoder
);
  timeunit 1ns;
  timeprecision 1ps;
  // bus is not held through the decode cycle; junk there exposes late sampling
  assign instr_word = instr_taken ? ~word_in : word_in;
endmodule : mrid_prog_mem

`default_nettype wire

/* File: test_mid_range_instruction_decode.sv */
// self-checking bench for the instruction decoder
`default_nettype none

module test_mid_range_instruction_decode import mrid_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk = 1'b0, rst_n = 1'b0, test_true = 1'b0;
  logic               instr_taken, nop_cycle, lit_long, result_to_w, result_to_file, pc_alter, skip_op;
  logic [INSTR_W-1:0] word_in = '0, instr_word;
  mrid_class_e        op_class, e_class;
  logic [5:0]         op_code;
  logic [FILE_W-1:0]  file_addr;
  logic [BIT_W-1:0]   bit_sel;
  logic [LIT_L_W-1:0] literal;
  logic [1:0]         q_phase;
  logic [15:0]        e_lit;
  logic               e_long, e_w, e_f, e_pc, e_skip;
  int                 mismatches = 0, samples_checked = 0, cycles = 0, next_gap = 0;
  // hand-picked corners: {test_true, word}
  logic [14:0] corner [16] = '{15'h0100, 15'h017F, 15'h0000, 15'h0060, 15'h0082, 15'h4BA5, 15'h0BA5,
    15'h4F7F, 15'h1782, 15'h5C7F, 15'h2FFF, 15'h2000, 15'h30A5, 15'h345A, 15'h0008, 15'h0009};

  always #5 clk = ~clk;

  mrid_decode DUT (.clk(clk), .rst_n(rst_n), .instr_word(instr_word), .test_true(test_true),
    .instr_taken(instr_taken), .nop_cycle(nop_cycle), .op_class(op_class), .op_code(op_code),
    .file_addr(file_addr), .bit_sel(bit_sel), .literal(literal), .lit_long(lit_long),
    .result_to_w(result_to_w), .result_to_file(result_to_file), .pc_alter(pc_alter),
    .skip_op(skip_op), .q_phase(q_phase));

  mrid_prog_mem PMEM (.instr_taken(instr_taken), .word_in(word_in), .instr_word(instr_word));

  ////////////////////////////////////////////////////////////////////////////////
  task close_out;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out

  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // expected decode of one word; don't-care bits take no part in it
  function automatic void model(input logic [13:0] w);
    logic [1:0] g;
    g = w[13:12];
    e_class = g == GRP_BIT ? MRID_CLS_BIT : (g == GRP_BYTE && w[11:7] != 5'h0) ? MRID_CLS_BYTE : MRID_CLS_LITCTL;
    e_long = g == GRP_JUMP;
    e_lit = e_long ? {5'h0, w[10:0]} : (g == 2'h3) ? {8'h0, w[7:0]} : 16'h0;
    e_w = (e_class == MRID_CLS_BYTE && !w[7]) || g == 2'h3;
    e_f = e_class == MRID_CLS_BYTE && w[7];
    e_skip = (e_class == MRID_CLS_BYTE && (w[11:8] == BYTE_DECSKIP || w[11:8] == BYTE_INCSKIP))
      || (g == GRP_BIT && w[11:10] >> 1 == BIT_TEST_HI);
    e_pc = e_long || (g == 2'h3 && w[11:10] == LIT_RETLIT) || w == CTL_RETURN || w == CTL_RETINT
      || (w[6:0] == PCL_ADDR_RST && (e_f || (g == GRP_BIT && !w[11])));
  endfunction : model

  // present one word, check its decode, its four periods and any flush cycle
  task run(input logic [13:0] w, input logic t);
    int n;
    n = 0;
    word_in = w;
    model(w);
    do begin
      @(negedge clk);
      n++;
    end while (instr_taken !== 1'b1 && n < 12);
    // skip condition belongs to this word; it must stand until the edge that ends it
    test_true = t;
    if (next_gap > 0) chk("cycles", 16'(next_gap), 16'(n));
    chk("class", 16'(e_class), 16'(op_class));
    chk("opcode", 16'(w[13:8]), 16'(op_code));
    chk("file", 16'(w[6:0]), 16'(file_addr));
    chk("bit", 16'(w[9:7]), 16'(bit_sel));
    chk("literal", e_lit, {5'h0, literal});
    chk("long", 16'(e_long), 16'(lit_long));
    chk("dest", 16'({e_w, e_f}), 16'({result_to_w, result_to_file}));
    chk("flow", 16'({e_pc, e_skip}), 16'({pc_alter, skip_op}));
    for (int k = 0; k < 4; k++) begin
      if (k > 0) @(negedge clk);
      chk("phase", 16'({k == 0, 2'(k)}), 16'({instr_taken, q_phase}));
    end
    next_gap = 1;
    if (e_pc || (e_skip && t)) begin
      @(negedge clk);
      chk("flush", 16'h0010, 16'({nop_cycle, instr_taken, result_to_w, result_to_file, pc_alter | skip_op}));
      next_gap = 4;
    end
  endtask : run

  ////////////////////////////////////////////////////////////////////////////////
  // hang guard, well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      close_out();
    end
  end

  initial begin
    void'($urandom(32'hF666));
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    foreach (corner[i]) run(corner[i][13:0], corner[i][14]);
    repeat (60) run(14'($urandom), 1'($urandom));
    close_out();
  end
endmodule : test_mid_range_instruction_decode

`default_nettype wire
